/* shared/gpb_pkg.sv */
// Shared constants for the three-port general-purpose I/O block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`default_nettype none

package gpb_pkg;

   // Bus widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register indices; byte address is four times the index
   localparam logic [3:0] IDX_PORTA_LATCH = 4'h0;
   localparam logic [3:0] IDX_PORTB_LATCH = 4'h1;
   localparam logic [3:0] IDX_PORTC_LATCH = 4'h2;
   localparam logic [3:0] IDX_PORTA_DIR = 4'h4;
   localparam logic [3:0] IDX_PORTB_DIR = 4'h5;
   localparam logic [3:0] IDX_PORTC_DIR = 4'h6;
   localparam logic [3:0] IDX_PORTA_PULL = 4'h8;
   localparam logic [3:0] IDX_PORTC_PULL = 4'h9;

   // Byte address layout: index sits in bits 5:2
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 5;

   // Values after reset
   localparam logic [7:0] RST_PORTA_DIR = 8'h00;
   localparam logic [7:0] RST_PORTB_DIR = 8'h00;
   localparam logic [6:0] RST_PORTC_DIR = 7'h00;
   localparam logic [7:0] RST_PORTA_PULL = 8'h00;
   localparam logic [6:0] RST_PORTC_PULL = 7'h00;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Port C pin positions taken over by the CAN controller
   localparam int PC_CAN_TX_BIT = 0;
   localparam int PC_CAN_RX_BIT = 1;

endpackage

`default_nettype wire

/* sim/gpb_ports_tb_top.sv */
// Self-checking bench for the three-port I/O block.
// Assumes an AXI4-Lite slave with one register per aligned word.
`timescale 1ns/1ps
`default_nettype none

module gpb_ports_tb_top;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'h0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, can_rx;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] pa_pin = 8'h00;
   logic [7:0] kbd_en = 8'h00;
   logic [7:0] kbd_pol = 8'h00;
   logic [7:0] pb_pin = 8'h00;
   logic [7:0] adc_sel = 8'h00;
   logic [6:0] pc_pin = 7'h00;
   logic can_take = 1'b0;
   logic can_tx = 1'b0;
   logic [7:0] pa_out, pa_oe, pa_pu, pa_pd, pb_out, pb_oe, pb_an;
   logic [6:0] pc_out, pc_oe, pc_pu;
   int num_errors = 0;
   int comparisons = 0;

   gpb_ports dut (.MCLK_IN(mclk), .RST_N_IN(rst_n), .CE_IN(ce),
      .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
      .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
      .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
      .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
      .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
      .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
      .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
      .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
      .S_AXI_RREADY_IN(rready), .PORTA_PIN_IN(pa_pin),
      .PORTA_PIN_OUT(pa_out), .PORTA_PIN_OE_OUT(pa_oe),
      .PORTA_PULLUP_OUT(pa_pu), .PORTA_PULLDOWN_OUT(pa_pd),
      .KEYPAD_INPUTS_EN_IN(kbd_en), .KEYPAD_POLARITY_IN(kbd_pol),
      .PORTB_PIN_IN(pb_pin), .PORTB_PIN_OUT(pb_out),
      .PORTB_PIN_OE_OUT(pb_oe), .PORTB_ANALOG_INPUTS_OUT(pb_an),
      .ADC_PIN_SELECT_IN(adc_sel), .PORTC_PIN_IN(pc_pin),
      .PORTC_PIN_OUT(pc_out), .PORTC_PIN_OE_OUT(pc_oe),
      .PORTC_PULLUP_OUT(pc_pu), .CAN_PIN_TAKEOVER_IN(can_take),
      .CAN_TRANSMIT_PIN_IN(can_tx), .CAN_RECEIVE_PIN_OUT(can_rx));

   always #10 mclk = ~mclk;

   function automatic logic [7:0] ra(input logic [3:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction

   task automatic check(input string name, input logic [7:0] seen,
         input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      if (num_errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Pin inputs pass a synchroniser and filter, so give them time to land
   task automatic settle;
      repeat (6) @(negedge mclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d,
         input logic [3:0] s, output logic [1:0] resp);
      bit aw_pend;
      bit w_pend;
      bit aw_hs;
      bit w_hs;
      int n;
      @(posedge mclk);
      aw_pend = 1;
      w_pend = 1;
      n = 0;
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while ((aw_pend || w_pend) && n < 50) begin
         @(negedge mclk);
         aw_hs = aw_pend && (awready === 1'b1);
         w_hs = w_pend && (wready === 1'b1);
         @(posedge mclk);
         n++;
         if (aw_hs) begin
            awvalid <= 1'b0;
            aw_pend = 0;
         end
         if (w_hs) begin
            wvalid <= 1'b0;
            w_pend = 0;
         end
      end
      bready <= 1'b1;
      do begin
         @(negedge mclk);
         n++;
      end while (bvalid !== 1'b1 && n < 100);
      resp = bresp;
      @(posedge mclk);
      bready <= 1'b0;
      if (n >= 100) num_errors++;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] data,
         output logic [1:0] resp);
      int n;
      @(posedge mclk);
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(negedge mclk);
         n++;
      end while (arready !== 1'b1 && n < 50);
      @(posedge mclk);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do begin
         @(negedge mclk);
         n++;
      end while (rvalid !== 1'b1 && n < 100);
      data = rdata;
      resp = rresp;
      @(posedge mclk);
      rready <= 1'b0;
      if (n >= 100) num_errors++;
   endtask

   task automatic wreg(input logic [3:0] idx, input logic [7:0] d);
      logic [1:0] r;
      wr(ra(idx), d, 4'h1, r);
      check("wr resp", {6'h00, r}, {6'h00, gpb_pkg::RESP_OKAY});
   endtask

   // Low byte is the register; the response must be OKAY
   task automatic rchk(input string name, input logic [3:0] idx,
         input logic [7:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rd(ra(idx), d, r);
      check(name, d[7:0], exp);
      check(name, d[31:24] | d[23:16] | d[15:8], 8'h00);
      check(name, {6'h00, r}, {6'h00, gpb_pkg::RESP_OKAY});
   endtask

   task automatic t_reset_values;
      rchk("porta dir", gpb_pkg::IDX_PORTA_DIR, 8'h00);
      rchk("portb dir", gpb_pkg::IDX_PORTB_DIR, 8'h00);
      rchk("portc dir", gpb_pkg::IDX_PORTC_DIR, 8'h00);
      rchk("porta pull", gpb_pkg::IDX_PORTA_PULL, 8'h00);
      rchk("portc pull", gpb_pkg::IDX_PORTC_PULL, 8'h00);
      check("portb oe", pb_oe, 8'h00);
   endtask

   task automatic t_port_b;
      @(posedge mclk);
      pb_pin <= 8'h5a;
      wreg(gpb_pkg::IDX_PORTB_LATCH, 8'ha5);
      settle;
      rchk("portb in", gpb_pkg::IDX_PORTB_LATCH, 8'h5a);
      wreg(gpb_pkg::IDX_PORTB_DIR, 8'h0f);
      settle;
      rchk("portb mix", gpb_pkg::IDX_PORTB_LATCH, 8'h55);
      check("portb oe", pb_oe, 8'h0f);
      check("portb out", pb_out, 8'ha5);
      wreg(gpb_pkg::IDX_PORTB_LATCH, 8'h3c);
      settle;
      rchk("portb mix2", gpb_pkg::IDX_PORTB_LATCH, 8'h5c);
      check("portb out2", pb_out, 8'h3c);
      rchk("portb dir", gpb_pkg::IDX_PORTB_DIR, 8'h0f);
      @(posedge mclk);
      adc_sel <= 8'h03;
      settle;
      check("portb oe adc", pb_oe, 8'h0c);
      check("portb analog", pb_an, 8'h03);
      // With the clock enable low the outputs must hold their last state
      @(posedge mclk);
      ce <= 1'b0;
      adc_sel <= 8'h00;
      settle;
      check("portb oe frozen", pb_oe, 8'h0c);
      @(posedge mclk);
      ce <= 1'b1;
      settle;
      check("portb oe back", pb_oe, 8'h0f);
   endtask

   task automatic t_port_c;
      @(posedge mclk);
      pc_pin <= 7'h55;
      wreg(gpb_pkg::IDX_PORTC_LATCH, 8'haa);
      wreg(gpb_pkg::IDX_PORTC_PULL, 8'h32);
      wreg(gpb_pkg::IDX_PORTC_DIR, 8'h0f);
      settle;
      rchk("portc mix", gpb_pkg::IDX_PORTC_LATCH, 8'h5a);
      check("portc oe", {1'b0, pc_oe}, 8'h0f);
      check("portc out", {1'b0, pc_out}, 8'h2a);
      check("portc pullup", {1'b0, pc_pu}, 8'h30);
      rchk("portc pull", gpb_pkg::IDX_PORTC_PULL, 8'h32);
      rchk("portc dir", gpb_pkg::IDX_PORTC_DIR, 8'h0f);
      @(posedge mclk);
      can_take <= 1'b1;
      can_tx <= 1'b1;
      pc_pin <= 7'h02;
      settle;
      check("can oe", {1'b0, pc_oe}, 8'h0d);
      check("can tx", {7'h00, pc_out[0]}, 8'h01);
      check("can rx", {7'h00, can_rx}, 8'h01);
      check("can pullup", {1'b0, pc_pu}, 8'h32);
      @(posedge mclk);
      can_take <= 1'b0;
   endtask

   task automatic t_port_a;
      @(posedge mclk);
      pa_pin <= 8'h99;
      wreg(gpb_pkg::IDX_PORTA_LATCH, 8'hc3);
      wreg(gpb_pkg::IDX_PORTA_PULL, 8'hff);
      wreg(gpb_pkg::IDX_PORTA_DIR, 8'h0f);
      settle;
      rchk("porta mix", gpb_pkg::IDX_PORTA_LATCH, 8'h93);
      check("porta oe", pa_oe, 8'h0f);
      check("porta out", pa_out, 8'hc3);
      check("porta pullup", pa_pu, 8'hf0);
      wreg(gpb_pkg::IDX_PORTA_PULL, 8'h5a);
      settle;
      check("porta pullup2", pa_pu, 8'h50);
      @(posedge mclk);
      kbd_en <= 8'hf0;
      kbd_pol <= 8'h30;
      settle;
      check("keypad pullup", pa_pu, 8'hc0);
      check("keypad pulldown", pa_pd, 8'h30);
      rchk("porta pull", gpb_pkg::IDX_PORTA_PULL, 8'h5a);
   endtask

   task automatic t_bad_addr;
      logic [31:0] d;
      logic [1:0] r;
      wr(8'h3c, 8'hff, 4'h1, r);
      check("bad wr resp", {6'h00, r}, {6'h00, gpb_pkg::RESP_SLVERR});
      rd(8'h3c, d, r);
      check("bad rd resp", {6'h00, r}, {6'h00, gpb_pkg::RESP_SLVERR});
      check("bad rd data", d[7:0], 8'h00);
      rd(8'h05, d, r);
      check("odd rd resp", {6'h00, r}, {6'h00, gpb_pkg::RESP_SLVERR});
      check("odd rd data", d[7:0], 8'h00);
      // Lane 0 off: answered OKAY, latch must keep 3c for the reset test
      wr(ra(gpb_pkg::IDX_PORTB_LATCH), 8'h00, 4'h0, r);
      check("lane0 resp", {6'h00, r}, {6'h00, gpb_pkg::RESP_OKAY});
   endtask

   // Latches must survive a reset while directions and pulls clear
   task automatic t_second_reset;
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      settle;
      check("portb out kept", pb_out, 8'h3c);
      check("portc out kept", {1'b0, pc_out}, 8'h2a);
      check("portb oe clr", pb_oe, 8'h00);
      check("portc oe clr", {1'b0, pc_oe}, 8'h00);
      check("porta oe clr", pa_oe, 8'h00);
      check("portc pull clr", {1'b0, pc_pu}, 8'h00);
   endtask

   initial begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset_values;
      t_port_b;
      t_port_c;
      t_port_a;
      t_bad_addr;
      t_second_reset;
      tally_and_finish;
   end

   // The whole run needs a few hundred cycles; this bounds a hang
   initial begin
      repeat (20000) @(posedge mclk);
      num_errors++;
      tally_and_finish;
   end
endmodule

`default_nettype wire

/* verilog/gpb_ports.sv */
// Port A pull control and read path, port B and port C I/O logic.
// Assumes AXI4-Lite on MCLK_IN; pin inputs arrive asynchronously;
// converter, keypad and CAN controls come from logic on MCLK_IN.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Each port A pin has its own pullup enable; set connects the pullup.
// - Port A pullup is off on output pins, back on when input again.
// - Keypad port A inputs get pullup or pulldown by keypad polarity.
// - Port B latch is 8 bits, read/write, untouched by reset.
// - Port B direction bit 1 enables the output buffer, 0 makes an input.
// - Reset clears all port B direction bits.
// - Port B read gives latch on outputs, pin level on inputs.
// - Latch writes always land; on inputs reads still show the pin.
// - ADC-selected port B pin is analog input, overriding port control.
// - Port C has seven pins with latch and direction; reset keeps latch.
// - Reset clears port C direction; direction 1 enables the output buffer.
// - Port C read gives latch on outputs, pin level on inputs.
// - CAN takeover puts receive on pin 1 and transmit on pin 0.
// - Port C pullup acts only when its bit is set and pin is input.
// - Port C pullup is removed on outputs and restored on inputs.
// - Port A read gives latch on outputs, pin level on inputs.
// - Reset clears all port A direction bits.
module gpb_ports (
   input wire logic MCLK_IN,
   input wire logic RST_N_IN,
   input wire logic CE_IN,
   input wire logic [7:0] S_AXI_AWADDR_IN,
   input wire logic S_AXI_AWVALID_IN,
   output logic S_AXI_AWREADY_OUT,
   input wire logic [31:0] S_AXI_WDATA_IN,
   input wire logic [3:0] S_AXI_WSTRB_IN,
   input wire logic S_AXI_WVALID_IN,
   output logic S_AXI_WREADY_OUT,
   output logic [1:0] S_AXI_BRESP_OUT,
   output logic S_AXI_BVALID_OUT,
   input wire logic S_AXI_BREADY_IN,
   input wire logic [7:0] S_AXI_ARADDR_IN,
   input wire logic S_AXI_ARVALID_IN,
   output logic S_AXI_ARREADY_OUT,
   output logic [31:0] S_AXI_RDATA_OUT,
   output logic [1:0] S_AXI_RRESP_OUT,
   output logic S_AXI_RVALID_OUT,
   input wire logic S_AXI_RREADY_IN,
   input wire logic [7:0] PORTA_PIN_IN,
   output logic [7:0] PORTA_PIN_OUT,
   output logic [7:0] PORTA_PIN_OE_OUT,
   output logic [7:0] PORTA_PULLUP_OUT,
   output logic [7:0] PORTA_PULLDOWN_OUT,
   input wire logic [7:0] KEYPAD_INPUTS_EN_IN,
   input wire logic [7:0] KEYPAD_POLARITY_IN,
   input wire logic [7:0] PORTB_PIN_IN,
   output logic [7:0] PORTB_PIN_OUT,
   output logic [7:0] PORTB_PIN_OE_OUT,
   output logic [7:0] PORTB_ANALOG_INPUTS_OUT,
   input wire logic [7:0] ADC_PIN_SELECT_IN,
   input wire logic [6:0] PORTC_PIN_IN,
   output logic [6:0] PORTC_PIN_OUT,
   output logic [6:0] PORTC_PIN_OE_OUT,
   output logic [6:0] PORTC_PULLUP_OUT,
   input wire logic CAN_PIN_TAKEOVER_IN,
   input wire logic CAN_TRANSMIT_PIN_IN,
   output logic CAN_RECEIVE_PIN_OUT
);

   // Register index decode, shared by the read and write paths
   function automatic logic [4:0] reg_decode(input logic [7:0] addr);
      logic hit;
      logic [3:0] idx;
      idx = addr[gpb_pkg::IDX_MSB:gpb_pkg::IDX_LSB];
      hit = 1'b0;
      if (addr[1:0] == 2'h0 && addr[7:6] == 2'h0) begin
         unique case (idx)
            gpb_pkg::IDX_PORTA_LATCH, gpb_pkg::IDX_PORTB_LATCH,
            gpb_pkg::IDX_PORTC_LATCH, gpb_pkg::IDX_PORTA_DIR,
            gpb_pkg::IDX_PORTB_DIR, gpb_pkg::IDX_PORTC_DIR,
            gpb_pkg::IDX_PORTA_PULL, gpb_pkg::IDX_PORTC_PULL: hit = 1'b1;
            default: hit = 1'b0;
         endcase
      end
      return {hit, idx};
   endfunction

   logic [7:0] porta_latch_q;
   logic [7:0] portb_latch_q;
   logic [6:0] portc_latch_q;
   logic [7:0] porta_direction_q;
   logic [7:0] portb_direction_q;
   logic [6:0] portc_direction_q;
   logic [7:0] porta_pull_enable_q;
   logic [6:0] portc_pull_enable_q;

   // Pin synchronisers: stage 1 feeds stage 2 only
   logic [22:0] pin_s1_q;
   logic [22:0] pin_s2_q;
   logic [22:0] pin_s3_q;
   logic [22:0] pin_f_q;
   logic [7:0] pa_pin;
   logic [7:0] pb_pin;
   logic [6:0] pc_pin;

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         pin_s1_q <= 23'h00_0000;
         pin_s2_q <= 23'h00_0000;
         pin_s3_q <= 23'h00_0000;
         pin_f_q <= 23'h00_0000;
      end else if (CE_IN) begin
         pin_s1_q <= {PORTC_PIN_IN, PORTB_PIN_IN, PORTA_PIN_IN};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         // A level only counts once two stages agree, filtering runts
         pin_f_q <= (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
      end
   end

   assign pa_pin = pin_f_q[7:0];
   assign pb_pin = pin_f_q[15:8];
   assign pc_pin = pin_f_q[22:16];

   // Write channel capture
   logic aw_have_q;
   logic w_have_q;
   logic [7:0] aw_addr_q;
   logic [7:0] w_data_q;
   logic w_lane0_q;
   logic do_wr;
   logic [4:0] wr_dec;
   logic wr_en;

   assign do_wr = aw_have_q & w_have_q & ~S_AXI_BVALID_OUT;
   assign wr_dec = reg_decode(aw_addr_q);
   assign wr_en = do_wr & wr_dec[4] & w_lane0_q;

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         S_AXI_AWREADY_OUT <= 1'b0;
      end else if (CE_IN) begin
         if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR_IN;
            S_AXI_AWREADY_OUT <= 1'b0;
         end else if (do_wr) begin
            aw_have_q <= 1'b0;
         end else if (!aw_have_q && !S_AXI_BVALID_OUT) begin
            S_AXI_AWREADY_OUT <= 1'b1;
         end
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         w_have_q <= 1'b0;
         w_data_q <= 8'h00;
         w_lane0_q <= 1'b0;
         S_AXI_WREADY_OUT <= 1'b0;
      end else if (CE_IN) begin
         if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
            w_have_q <= 1'b1;
            w_data_q <= S_AXI_WDATA_IN[7:0];
            w_lane0_q <= S_AXI_WSTRB_IN[0];
            S_AXI_WREADY_OUT <= 1'b0;
         end else if (do_wr) begin
            w_have_q <= 1'b0;
         end else if (!w_have_q && !S_AXI_BVALID_OUT) begin
            S_AXI_WREADY_OUT <= 1'b1;
         end
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         S_AXI_BVALID_OUT <= 1'b0;
         S_AXI_BRESP_OUT <= gpb_pkg::RESP_OKAY;
      end else if (CE_IN) begin
         if (do_wr) begin
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT <= wr_dec[4] ? gpb_pkg::RESP_OKAY :
                               gpb_pkg::RESP_SLVERR;
         end else if (S_AXI_BREADY_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
         end
      end
   end

   // Data latches have no reset: their contents survive it
   always_ff @(posedge MCLK_IN) begin
      if (CE_IN && wr_en) begin
         if (wr_dec[3:0] == gpb_pkg::IDX_PORTA_LATCH) begin
            porta_latch_q <= w_data_q;
         end
         if (wr_dec[3:0] == gpb_pkg::IDX_PORTB_LATCH) begin
            portb_latch_q <= w_data_q;
         end
         if (wr_dec[3:0] == gpb_pkg::IDX_PORTC_LATCH) begin
            portc_latch_q <= w_data_q[6:0];
         end
      end
   end

   // Reset may arrive with the clock enable low; it still wins
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         porta_direction_q <= gpb_pkg::RST_PORTA_DIR;
         portb_direction_q <= gpb_pkg::RST_PORTB_DIR;
         portc_direction_q <= gpb_pkg::RST_PORTC_DIR;
         porta_pull_enable_q <= gpb_pkg::RST_PORTA_PULL;
         portc_pull_enable_q <= gpb_pkg::RST_PORTC_PULL;
      end else if (CE_IN && wr_en) begin
         unique case (wr_dec[3:0])
            gpb_pkg::IDX_PORTA_DIR: porta_direction_q <= w_data_q;
            gpb_pkg::IDX_PORTB_DIR: portb_direction_q <= w_data_q;
            gpb_pkg::IDX_PORTC_DIR: portc_direction_q <= w_data_q[6:0];
            gpb_pkg::IDX_PORTA_PULL: porta_pull_enable_q <= w_data_q;
            gpb_pkg::IDX_PORTC_PULL: portc_pull_enable_q <= w_data_q[6:0];
            default: ;
         endcase
      end
   end

   // Read channel: data is formed at the address handshake
   logic [4:0] rd_dec;
   logic [7:0] rd_byte;

   assign rd_dec = reg_decode(S_AXI_ARADDR_IN);

   always_comb begin
      rd_byte = 8'h00;
      unique case (rd_dec[3:0])
         gpb_pkg::IDX_PORTA_LATCH:
            rd_byte = (porta_latch_q & porta_direction_q) |
                      (pa_pin & ~porta_direction_q);
         gpb_pkg::IDX_PORTB_LATCH:
            rd_byte = (portb_latch_q & portb_direction_q) |
                      (pb_pin & ~portb_direction_q);
         gpb_pkg::IDX_PORTC_LATCH:
            rd_byte = {1'b0, (portc_latch_q & portc_direction_q) |
                             (pc_pin & ~portc_direction_q)};
         gpb_pkg::IDX_PORTA_DIR: rd_byte = porta_direction_q;
         gpb_pkg::IDX_PORTB_DIR: rd_byte = portb_direction_q;
         gpb_pkg::IDX_PORTC_DIR: rd_byte = {1'b0, portc_direction_q};
         gpb_pkg::IDX_PORTA_PULL: rd_byte = porta_pull_enable_q;
         gpb_pkg::IDX_PORTC_PULL: rd_byte = {1'b0, portc_pull_enable_q};
         default: rd_byte = 8'h00;
      endcase
      if (!rd_dec[4]) begin
         rd_byte = 8'h00;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         S_AXI_ARREADY_OUT <= 1'b0;
         S_AXI_RVALID_OUT <= 1'b0;
         S_AXI_RDATA_OUT <= 32'h0000_0000;
         S_AXI_RRESP_OUT <= gpb_pkg::RESP_OKAY;
      end else if (CE_IN) begin
         if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            S_AXI_ARREADY_OUT <= 1'b0;
            S_AXI_RVALID_OUT <= 1'b1;
            S_AXI_RDATA_OUT <= {24'h00_0000, rd_byte};
            S_AXI_RRESP_OUT <= rd_dec[4] ? gpb_pkg::RESP_OKAY :
                               gpb_pkg::RESP_SLVERR;
         end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
         end else if (!S_AXI_RVALID_OUT) begin
            S_AXI_ARREADY_OUT <= 1'b1;
         end
      end
   end

   // Pin drive and pull control, all from flip-flops
   logic [7:0] pa_kbd_in;
   logic [7:0] pb_drive;
   logic [6:0] pc_oe_d;
   logic [6:0] pc_out_d;

   assign pa_kbd_in = KEYPAD_INPUTS_EN_IN & ~porta_direction_q;
   assign pb_drive = portb_direction_q & ~ADC_PIN_SELECT_IN;

   always_comb begin
      pc_oe_d = portc_direction_q;
      pc_out_d = portc_latch_q;
      if (CAN_PIN_TAKEOVER_IN) begin
         pc_oe_d[gpb_pkg::PC_CAN_TX_BIT] = 1'b1;
         pc_out_d[gpb_pkg::PC_CAN_TX_BIT] = CAN_TRANSMIT_PIN_IN;
         pc_oe_d[gpb_pkg::PC_CAN_RX_BIT] = 1'b0;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         PORTA_PIN_OUT <= 8'h00;
         PORTA_PIN_OE_OUT <= 8'h00;
         PORTA_PULLUP_OUT <= 8'h00;
         PORTA_PULLDOWN_OUT <= 8'h00;
      end else if (CE_IN) begin
         PORTA_PIN_OUT <= porta_latch_q;
         PORTA_PIN_OE_OUT <= porta_direction_q;
         // Keypad pins pick their pull by polarity, others by enable bit
         PORTA_PULLUP_OUT <= (porta_pull_enable_q & ~porta_direction_q &
                              ~KEYPAD_INPUTS_EN_IN) |
                             (pa_kbd_in & ~KEYPAD_POLARITY_IN);
         PORTA_PULLDOWN_OUT <= pa_kbd_in & KEYPAD_POLARITY_IN;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         PORTB_PIN_OUT <= 8'h00;
         PORTB_PIN_OE_OUT <= 8'h00;
         PORTB_ANALOG_INPUTS_OUT <= 8'h00;
      end else if (CE_IN) begin
         PORTB_PIN_OUT <= portb_latch_q;
         PORTB_PIN_OE_OUT <= pb_drive;
         PORTB_ANALOG_INPUTS_OUT <= ADC_PIN_SELECT_IN;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         PORTC_PIN_OUT <= 7'h00;
         PORTC_PIN_OE_OUT <= 7'h00;
         PORTC_PULLUP_OUT <= 7'h00;
         CAN_RECEIVE_PIN_OUT <= 1'b0;
      end else if (CE_IN) begin
         PORTC_PIN_OUT <= pc_out_d;
         PORTC_PIN_OE_OUT <= pc_oe_d;
         PORTC_PULLUP_OUT <= portc_pull_enable_q & ~pc_oe_d;
         CAN_RECEIVE_PIN_OUT <= pc_pin[gpb_pkg::PC_CAN_RX_BIT];
      end
   end

   // Checks
   chk_dir_reset_clear: assert property (
      @(posedge MCLK_IN) !RST_N_IN |=>
         (portb_direction_q == 8'h00 && portc_direction_q == 7'h00 &&
          porta_direction_q == 8'h00))
      else $error("direction bits not cleared by reset");

   chk_porta_pull_gate: assert property (
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
      ($past(CE_IN) && $past(RST_N_IN) && $past(KEYPAD_INPUTS_EN_IN) == 8'h00)
         |-> PORTA_PULLUP_OUT ==
             $past(porta_pull_enable_q & ~porta_direction_q))
      else $error("port A pullup not gated by direction");

   chk_keypad_pull_sel: assert property (
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
      ($past(CE_IN) && $past(RST_N_IN)) |->
         (PORTA_PULLDOWN_OUT == $past(pa_kbd_in & KEYPAD_POLARITY_IN)) &&
         ((PORTA_PULLUP_OUT & PORTA_PULLDOWN_OUT) == 8'h00))
      else $error("keypad pull selection wrong");

   chk_portb_latch_wr: assert property (
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
      (CE_IN && wr_en && wr_dec[3:0] == gpb_pkg::IDX_PORTB_LATCH) |=>
         portb_latch_q == $past(w_data_q))
      else $error("port B latch write lost");

   chk_portb_drive: assert property (
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
      ($past(CE_IN) && $past(RST_N_IN)) |->
         PORTB_PIN_OE_OUT ==
         $past(portb_direction_q & ~ADC_PIN_SELECT_IN))
      else $error("port B output enable wrong");

   chk_portb_read_mux: assert property (
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
      (CE_IN && S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT &&
       S_AXI_ARADDR_IN == {2'h0, gpb_pkg::IDX_PORTB_LATCH, 2'h0}) |=>
         S_AXI_RVALID_OUT && S_AXI_RDATA_OUT[7:0] ==
         $past((portb_latch_q & portb_direction_q) |
               (pb_pin & ~portb_direction_q)))
      else $error("port B read mux wrong");

   chk_portc_read_mux: assert property (
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
      (CE_IN && S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT &&
       S_AXI_ARADDR_IN == {2'h0, gpb_pkg::IDX_PORTC_LATCH, 2'h0}) |=>
         S_AXI_RDATA_OUT[7:0] == {1'b0, $past((portc_latch_q &
         portc_direction_q) | (pc_pin & ~portc_direction_q))})
      else $error("port C read mux wrong");

   chk_porta_read_mux: assert property (
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
      (CE_IN && S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT &&
       S_AXI_ARADDR_IN == {2'h0, gpb_pkg::IDX_PORTA_LATCH, 2'h0}) |=>
         S_AXI_RDATA_OUT[7:0] == $past((porta_latch_q & porta_direction_q) |
                                       (pa_pin & ~porta_direction_q)))
      else $error("port A read mux wrong");

   chk_can_takeover: assert property (
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
      ($past(CE_IN) && $past(RST_N_IN) && $past(CAN_PIN_TAKEOVER_IN)) |->
         PORTC_PIN_OE_OUT[1:0] == 2'h1 &&
         PORTC_PIN_OUT[0] == $past(CAN_TRANSMIT_PIN_IN))
      else $error("CAN pins not taken over");

   chk_portc_pullup: assert property (
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
      ($past(CE_IN) && $past(RST_N_IN)) |->
         (PORTC_PULLUP_OUT & PORTC_PIN_OE_OUT) == 7'h00 &&
         PORTC_PULLUP_OUT == ($past(portc_pull_enable_q) & ~PORTC_PIN_OE_OUT))
      else $error("port C pullup wrong");

   chk_dir_readback: assert property (
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
      (CE_IN && wr_en && wr_dec[3:0] == gpb_pkg::IDX_PORTB_DIR) |=>
         portb_direction_q == $past(w_data_q))
      else $error("direction write not held");

endmodule

`default_nettype wire
